// ==== dv/user_port_link_tb.sv ====
// Self-checking bench for the user port link.
// Assumes the user side model above and a 16-cycle E clock.
`timescale 1ns/10ps
module user_port_link_tb;
    import user_port_pkg::*;
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic [7:0]  wd;
        logic [7:0]  rd;
        logic        sel;
    } row_t;
    logic clock_in = 0, rst_n_in = 0, man_n = 1, bp = 0, e_clk = 0;
    logic cmd_valid = 0, irq_req = 0, x_en = 0, to_user = 1, sel_seen;
    logic done, irq, pop, push, cmd_en, cmd_rst_n, dir_n, xsel_n, xstb_n;
    logic xrdy_n, xoe, got, wr_seen, p_irq_n;
    logic [7:0] rdata, wdata, xdout, xwire, p_data, p_cmd, cwire, got_d, rd;
    logic [5:0] addr_seen;
    logic [3:0] stall = 4'hC;
    cmd_req_t   req = '0;
    cmd_pins_t  pins;
    int         err_total = 0, check_count = 0, pops = 0, e_cnt = 0, n;
    logic [7:0] got_q[$], push_q[$];
    row_t rows[9] = '{
        '{16'h0040, 1'h1, 8'h5A, 8'h00, 1'h1},
        '{16'h007F, 1'h1, 8'hA5, 8'h00, 1'h1},
        '{16'h0055, 1'h1, 8'h3C, 8'h00, 1'h1},
        '{16'h0040, 1'h0, 8'h00, 8'h5A, 1'h1},
        '{16'h007F, 1'h0, 8'h00, 8'hA5, 1'h1},
        '{16'h0055, 1'h0, 8'h00, 8'h3C, 1'h1},
        '{16'h003F, 1'h0, 8'h00, 8'h00, 1'h0},
        '{16'h0080, 1'h1, 8'h11, 8'h00, 1'h0},
        '{16'h0080, 1'h0, 8'h00, 8'h00, 1'h0}};
    // Wire levels from the link's enables; the user side model drives otherwise
    assign cwire = pins.data_oe ? pins.data : p_cmd;
    assign xwire = xoe ? xdout : p_data;
    always #5 clock_in = ~clock_in;
    always @(negedge clock_in)
    begin
        e_cnt <= e_cnt + 1;
        if (e_cnt % 8 == 7)
            e_clk <= ~e_clk;
    end
    always @(posedge clock_in)
    begin
        if (pop === 1'b1)
            pops <= pops + 1;
        if (push === 1'b1)
            push_q.push_back(wdata);
        if (got === 1'b1)
            got_q.push_back(got_d);
        if (pins.select_n === 1'b0)
        begin
            sel_seen  <= 1'b1;
            addr_seen <= pins.addr;
            wr_seen   <= pins.write_n;
        end
    end
    user_port_link dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .manual_reset_n_in(man_n), .backplane_reset_in(bp),
        .e_clock_in(e_clk), .cmd_valid_in(cmd_valid), .cmd_req_in(req),
        .cmd_done_out(done), .cmd_rdata_out(rdata), .irq_out(irq),
        .xfer_enable_in(x_en), .xfer_to_user_in(to_user),
        .fifo_valid_in(pops < 4), .fifo_data_in(8'h30 + 8'(pops)),
        .fifo_pop_out(pop), .fifo_push_out(push), .fifo_wdata_out(wdata),
        .user_irq_n_in(p_irq_n), .cmd_enable_out(cmd_en),
        .cmd_reset_n_out(cmd_rst_n), .cmd_pins_out(pins),
        .cmd_data_in(cwire), .xfer_dir_n_out(dir_n),
        .xfer_select_n_out(xsel_n), .xfer_strobe_n_out(xstb_n),
        .xfer_ready_n_in(xrdy_n), .xfer_data_out(xdout),
        .xfer_data_oe_out(xoe), .xfer_data_in(xwire));
    user_side_model part_u (.clock_in(clock_in), .reset_n_in(cmd_rst_n),
        .pins_in(pins), .irq_req_in(irq_req), .cmd_data_out(p_cmd),
        .irq_n_out(p_irq_n), .stall_in(stall), .dir_n_in(dir_n),
        .select_n_in(xsel_n), .strobe_n_in(xstb_n), .dev_data_in(xwire),
        .ready_n_out(xrdy_n), .data_out(p_data), .got_out(got),
        .got_data_out(got_d));
    task chk(input logic [7:0] val, input logic [7:0] exp);
        check_count++;
        if (val !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, val, exp);
        end
    endtask
    task summarize;
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task give_up;
        err_total++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
        summarize();
    endtask
    task tick(input int k);
        repeat (k) @(negedge clock_in);
    endtask
    task do_cmd(input row_t r);
        sel_seen = 1'b0;
        cmd_valid = 1'b1;
        req = '{r.addr, r.wr, r.wd};
        n = 0;
        do
        begin
            tick(1);
            n++;
        end
        while (done !== 1'b1 && n < 200);
        if (n >= 200)
            give_up();
        rd = rdata;
        cmd_valid = 1'b0;
        tick(1);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        tick(3);
        chk(8'(pins.select_n), 8'h01);
        chk(8'(xstb_n), 8'h01);
        chk(8'(cmd_rst_n), 8'h00);
        tick(2);
        rst_n_in = 1'b1;
        tick(2);
        foreach (rows[i])
        begin
            do_cmd(rows[i]);
            if (!rows[i].wr)
                chk(rd, rows[i].rd);
            chk(8'(sel_seen), 8'(rows[i].sel));
            if (rows[i].sel)
            begin
                chk(8'(addr_seen), 8'(rows[i].addr[5:0]));
                chk(8'(wr_seen), 8'(!rows[i].wr));
            end
        end
        repeat (40)
        begin
            tick(1);
            chk(8'(cmd_en), 8'(e_clk));
        end
        man_n = 1'b0;
        tick(3);
        chk(8'(cmd_rst_n), 8'h00);
        man_n = 1'b1;
        bp = 1'b1;
        tick(3);
        chk(8'(cmd_rst_n), 8'h00);
        bp = 1'b0;
        tick(3);
        chk(8'(cmd_rst_n), 8'h01);
        irq_req = 1'b1;
        tick(3);
        chk(8'(irq), 8'h01);
        irq_req = 1'b0;
        tick(3);
        chk(8'(irq), 8'h00);
        // Not configured: nothing may move
        tick(20);
        chk(8'(pops), 8'h00);
        chk(8'(xsel_n), 8'h01);
        x_en = 1'b1;
        for (n = 0; n < 600 && got_q.size() < 4; n++)
        begin
            tick(1);
            if (pops == 2)
                stall = 4'h0;
        end
        if (n >= 600)
            give_up();
        chk(8'(dir_n), 8'h00);
        chk(8'(xsel_n), 8'h00);
        tick(40);
        chk(8'(got_q.size()), 8'h04);
        foreach (got_q[i])
            chk(got_q[i], 8'h30 + 8'(i));
        x_en = 1'b0;
        tick(5);
        to_user = 1'b0;
        stall = 4'h3;
        x_en = 1'b1;
        for (n = 0; n < 600 && push_q.size() < 4; n++)
            tick(1);
        if (n >= 600)
            give_up();
        chk(8'(dir_n), 8'h01);
        x_en = 1'b0;
        for (int i = 0; i < 4; i++)
            chk(push_q[i], 8'hC0 + 8'(i));
        summarize();
    end
endmodule

// ==== dv/user_side_model.sv ====
// User hardware model on the far end of the ribbon cable.
// Assumes pins are sampled on clock_in; reset comes from cmd reset.
`timescale 1ns/10ps
module user_side_model
    import user_port_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        reset_n_in,
    // Command path
    input  wire cmd_pins_t   pins_in,
    input  wire logic        irq_req_in,
    output logic [7:0]       cmd_data_out,
    output logic             irq_n_out,
    // Transfer path
    input  wire logic [3:0]  stall_in,
    input  wire logic        dir_n_in,
    input  wire logic        select_n_in,
    input  wire logic        strobe_n_in,
    input  wire logic [7:0]  dev_data_in,
    output logic             ready_n_out,
    output logic [7:0]       data_out,
    output logic             got_out,
    output logic [7:0]       got_data_out
);
    logic [7:0] mem_r [64];
    logic [7:0] cmd_hold_r;
    logic [7:0] dat_hold_r;
    logic [7:0] next_r;
    logic [3:0] wait_r;
    logic       stb_q_r;
    logic       drive_r;
    wire        rd_en = !pins_in.select_n && pins_in.write_n;
    // Released lines show a changing pattern, never the last value
    assign cmd_data_out = rd_en ? mem_r[pins_in.addr] : ~cmd_hold_r;
    assign data_out     = drive_r ? next_r : ~dat_hold_r;
    assign irq_n_out    = !irq_req_in;
    always_ff @(posedge clock_in)
    begin
        cmd_hold_r <= cmd_data_out;
        dat_hold_r <= data_out;
        if (!pins_in.select_n && !pins_in.write_n)
            mem_r[pins_in.addr] <= pins_in.data;
    end
    // ****************************************
    // Byte handshake
    // ****************************************
    always_ff @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            ready_n_out <= 1'b1;
            wait_r      <= 4'h0;
            stb_q_r     <= 1'b1;
            drive_r     <= 1'b0;
            next_r      <= 8'hC0;
            got_out     <= 1'b0;
        end
        else
        begin
            stb_q_r <= strobe_n_in;
            got_out <= 1'b0;
            if (select_n_in || !dir_n_in)
                drive_r <= 1'b0;
            if (!select_n_in && stb_q_r && !strobe_n_in)
            begin
                ready_n_out <= 1'b1;
                wait_r      <= stall_in;
                if (!dir_n_in)
                begin
                    got_out      <= 1'b1;
                    got_data_out <= dev_data_in;
                end
                else
                begin
                    drive_r <= 1'b1;
                    if (drive_r)
                        next_r <= next_r + 8'h01;
                end
            end
            else if (ready_n_out && strobe_n_in)
            begin
                if (wait_r != 4'h0)
                    wait_r <= wait_r - 4'h1;
                else
                    ready_n_out <= 1'b0;
            end
        end
    end
endmodule

// ==== rtl/user_port_link.sv ====
// Buffered user port: command path and FIFO byte link to user hardware.
// Assumes a processor side that issues one command request at a time,
// an E clock sampled on clock_in and synchronous pin inputs.
//
// Functional notes
// - Command enable copies processor E clock
// - Select low for window 40 to 7F
// - Write line low for write, high read
// - Six-bit address valid during select
// - Data bus direction follows write line
// - Direction low means FIFO to user
// - Transfer select low once configured
// - Outbound strobe, partner latches byte
// - Inbound strobe, partner drives byte
// - Transfer bus direction follows dir line
`timescale 1ns/10ps
module user_port_link
    import user_port_pkg::*;
(
    // Clock and reset
    input  wire logic              clock_in,
    input  wire logic              rst_n_in,
    // Reset sources
    input  wire logic              manual_reset_n_in,
    input  wire logic              backplane_reset_in,
    // Processor side
    input  wire logic              e_clock_in,
    input  wire logic              cmd_valid_in,
    input  wire cmd_req_t          cmd_req_in,
    output logic                   cmd_done_out,
    output logic [DATA_W-1:0]      cmd_rdata_out,
    output logic                   irq_out,
    // FIFO side
    input  wire logic              xfer_enable_in,
    input  wire logic              xfer_to_user_in,
    input  wire logic              fifo_valid_in,
    input  wire logic [DATA_W-1:0] fifo_data_in,
    output logic                   fifo_pop_out,
    output logic                   fifo_push_out,
    output logic [DATA_W-1:0]      fifo_wdata_out,
    // Command pins
    input  wire logic              user_irq_n_in,
    output logic                   cmd_enable_out,
    output logic                   cmd_reset_n_out,
    output cmd_pins_t              cmd_pins_out,
    input  wire logic [DATA_W-1:0] cmd_data_in,
    // Transfer pins
    output logic                   xfer_dir_n_out,
    output logic                   xfer_select_n_out,
    output logic                   xfer_strobe_n_out,
    input  wire logic              xfer_ready_n_in,
    output logic [DATA_W-1:0]      xfer_data_out,
    output logic                   xfer_data_oe_out,
    input  wire logic [DATA_W-1:0] xfer_data_in
);

    // ********************************************
    // Helpers
    // ********************************************
    function automatic logic in_window(input logic [15:0] a);
        in_window = (a >= CMD_WIN_BASE) && (a <= CMD_WIN_LAST);
    endfunction

    // ********************************************
    // Reset and clock redrive
    // ********************************************
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            cmd_reset_n_out <= 1'b0;
            cmd_enable_out  <= 1'b0;
            irq_out         <= 1'b0;
        end
        else
        begin
            // Either source holds the far side in reset
            cmd_reset_n_out <= manual_reset_n_in && !backplane_reset_in;
            cmd_enable_out  <= e_clock_in;
            irq_out         <= !user_irq_n_in;
        end
    end

    // ********************************************
    // Command path
    // ********************************************
    typedef enum logic [1:0] {C_IDLE, C_HOLD, C_END} cmd_state_t;

    cmd_state_t cmd_state_r;
    logic       e_prev_r;
    logic       e_fall;

    assign e_fall = e_prev_r && !e_clock_in;

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            e_prev_r <= 1'b0;
        else
            e_prev_r <= e_clock_in;
    end

    // Access lasts until the end of the E high phase, like the processor
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            cmd_state_r           <= C_IDLE;
            cmd_pins_out.select_n <= RST_SELECT_N;
            cmd_pins_out.write_n  <= RST_WRITE_N;
            cmd_pins_out.addr     <= '0;
            cmd_pins_out.data     <= '0;
            cmd_pins_out.data_oe  <= 1'b0;
            cmd_done_out          <= 1'b0;
            cmd_rdata_out         <= '0;
        end
        else
        begin
            cmd_done_out <= 1'b0;
            case (cmd_state_r)
                C_IDLE:
                begin
                    if (cmd_valid_in && in_window(cmd_req_in.addr))
                    begin
                        cmd_pins_out.select_n <= 1'b0;
                        cmd_pins_out.write_n  <= !cmd_req_in.write;
                        cmd_pins_out.addr     <=
                            cmd_req_in.addr[CMD_ADDR_W-1:0];
                        cmd_pins_out.data     <= cmd_req_in.wdata;
                        cmd_pins_out.data_oe  <= cmd_req_in.write;
                        cmd_state_r           <= C_HOLD;
                    end
                    else if (cmd_valid_in)
                    begin
                        // Outside window: finish with no pin activity
                        cmd_done_out  <= 1'b1;
                        cmd_rdata_out <= '0;
                    end
                end
                C_HOLD:
                begin
                    if (e_fall)
                    begin
                        // Partner drives only on reads
                        if (cmd_pins_out.write_n)
                            cmd_rdata_out <= cmd_data_in;
                        cmd_pins_out.select_n <= 1'b1;
                        cmd_pins_out.data_oe  <= 1'b0;
                        cmd_done_out          <= 1'b1;
                        cmd_state_r           <= C_END;
                    end
                end
                C_END:
                begin
                    // Wait for the request to drop before another
                    if (!cmd_valid_in)
                        cmd_state_r <= C_IDLE;
                end
                default:
                    cmd_state_r <= C_IDLE;
            endcase
        end
    end

    a_cmd_select_win: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        $fell(cmd_pins_out.select_n) |->
        $past(in_window(cmd_req_in.addr) && cmd_valid_in))
        else $error("select outside address window");

    a_cmd_dir_write: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        !cmd_pins_out.select_n |->
        (cmd_pins_out.data_oe == !cmd_pins_out.write_n))
        else $error("command data drive disagrees with write line");

    a_cmd_stable: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        (!cmd_pins_out.select_n && $past(!cmd_pins_out.select_n))
        |-> $stable(cmd_pins_out.addr) && $stable(cmd_pins_out.write_n))
        else $error("command address moved during select");

    // ********************************************
    // Transfer path
    // ********************************************
    logic strobe_n;
    logic byte_done;
    logic want;
    logic done_d_r;

    // Outbound needs a byte held; inbound always wants one.
    // Pause one clock after a byte: the pop has not reached the FIFO yet,
    // so its valid flag would still count the byte just sent.
    assign want = !done_d_r && (xfer_to_user_in ? fifo_valid_in : 1'b1);

    // Enable gates the start too, so no strobe starts as select drops; a strobe already low still runs its full width
    xfer_strobe_gen u_strobe (
        .clock_in     (clock_in),
        .rst_n_in     (rst_n_in),
        .active_in    (xfer_enable_in && !xfer_select_n_out),
        .want_in      (want),
        .ready_n_in   (xfer_ready_n_in),
        .strobe_n_out (strobe_n),
        .done_out     (byte_done)
    );

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            xfer_select_n_out <= RST_SELECT_N;
            xfer_dir_n_out    <= RST_DIR_N;
            xfer_strobe_n_out <= RST_STROBE_N;
            xfer_data_out     <= '0;
            xfer_data_oe_out  <= 1'b0;
            fifo_pop_out      <= 1'b0;
            fifo_push_out     <= 1'b0;
            fifo_wdata_out    <= '0;
            done_d_r          <= 1'b0;
        end
        else
        begin
            xfer_select_n_out <= !xfer_enable_in;
            xfer_dir_n_out    <= !xfer_to_user_in;
            xfer_strobe_n_out <= strobe_n;
            // Bus driven only outbound while selected
            xfer_data_oe_out  <= xfer_enable_in && xfer_to_user_in;
            xfer_data_out     <= fifo_data_in;
            done_d_r          <= byte_done;
            // Outbound byte consumed once ready returns low after strobe
            fifo_pop_out      <= byte_done && !xfer_dir_n_out;
            // Inbound byte on bus once ready returns low
            fifo_push_out     <= byte_done && xfer_dir_n_out;
            if (byte_done)
                fifo_wdata_out <= xfer_data_in;
        end
    end

    a_xfer_sel_strobe: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        !xfer_strobe_n_out |-> $past(!xfer_select_n_out))
        else $error("strobe without transfer select");

    a_xfer_dir_oe: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        xfer_data_oe_out |-> !xfer_dir_n_out)
        else $error("transfer bus driven while inbound");

    a_xfer_one_move: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        !(fifo_pop_out && fifo_push_out))
        else $error("pop and push together");

endmodule

// ==== rtl/user_port_pkg.sv ====
// Shared constants and carrier types for the buffered user port.
// Assumes a single 100 MHz clock domain and synchronous pin inputs.
package user_port_pkg;

    // Address window of the command path
    localparam logic [15:0] CMD_WIN_BASE  = 16'h0040;
    localparam logic [15:0] CMD_WIN_LAST  = 16'h007F;
    localparam int          CMD_ADDR_W    = 6;
    localparam int          DATA_W        = 8;

    // Reset values of pin outputs
    localparam logic        RST_SELECT_N  = 1'h1;
    localparam logic        RST_WRITE_N   = 1'h1;
    localparam logic        RST_STROBE_N  = 1'h1;
    localparam logic        RST_DIR_N     = 1'h1;

    // Strobe low width in clocks (10 ns each)
    localparam int          CLK_NS        = 10;
    localparam int          STROBE_NS     = 40;
    localparam logic [3:0]  STROBE_CYC    =
        4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  GAP_CYC       = 4'h1;

    // Processor side command request
    typedef struct packed {
        logic [15:0] addr;
        logic        write;
        logic [7:0]  wdata;
    } cmd_req_t;

    // Command pins toward the user hardware
    typedef struct packed {
        logic                  select_n;
        logic                  write_n;
        logic [CMD_ADDR_W-1:0] addr;
        logic [7:0]            data;
        logic                  data_oe;
    } cmd_pins_t;

endpackage

// ==== rtl/xfer_strobe_gen.sv ====
// Data strobe generator for the byte-wide transfer path.
// Assumes ready_n input is synchronous to clock_in.
`timescale 1ns/10ps
module xfer_strobe_gen
    import user_port_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // Control
    input  wire logic       active_in,
    input  wire logic       want_in,
    input  wire logic       ready_n_in,
    // Strobe
    output logic            strobe_n_out,
    output logic            done_out
);

    // ********************************************
    // Strobe sequencer
    // ********************************************
    typedef enum logic [1:0] {S_IDLE, S_LOW, S_WAIT, S_GAP} stb_state_t;

    stb_state_t state_r;
    logic [3:0] cnt_r;

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            state_r      <= S_IDLE;
            cnt_r        <= 4'h0;
            strobe_n_out <= RST_STROBE_N;
            done_out     <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            case (state_r)
                S_IDLE:
                begin
                    // Only strobe when partner is ready
                    if (active_in && want_in && !ready_n_in)
                    begin
                        strobe_n_out <= 1'b0;
                        cnt_r        <= STROBE_CYC - 4'h1;
                        state_r      <= S_LOW;
                    end
                end
                S_LOW:
                begin
                    if (cnt_r == 4'h0)
                    begin
                        strobe_n_out <= 1'b1;
                        state_r      <= S_WAIT;
                    end
                    else
                    begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                S_WAIT:
                begin
                    // Partner lowers ready after the strobe
                    if (!ready_n_in)
                    begin
                        done_out <= 1'b1;
                        cnt_r    <= GAP_CYC;
                        state_r  <= S_GAP;
                    end
                end
                S_GAP:
                begin
                    if (cnt_r == 4'h1)
                        state_r <= S_IDLE;
                    else
                        cnt_r <= cnt_r - 4'h1;
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

    a_strobe_ready: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        $fell(strobe_n_out) |-> $past(!ready_n_in))
        else $error("strobe issued while partner not ready");

    sequence s_strobe_low;
        !strobe_n_out [*4];
    endsequence

    a_strobe_width: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        $fell(strobe_n_out) |-> s_strobe_low ##1 strobe_n_out)
        else $error("strobe width wrong");

endmodule
